// ---- rtl/pgate_pkg.sv ----
// Package with register map, field layout and reset values of the peripheral gate banks
package pgate_pkg;

  localparam int unsigned NUM_BANKS = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // Register indices on the plain port
  localparam logic [3:0] ADDR_BANK_4 = 4'h0;
  localparam logic [3:0] ADDR_BANK_5 = 4'h1;
  localparam logic [3:0] ADDR_BANK_6 = 4'h2;
  localparam logic [3:0] ADDR_BANK_7 = 4'h3;
  localparam logic [3:0] ADDR_BANK_8 = 4'h4;

  // Implemented-bit masks; other positions are dropped on write and read as zero
  localparam logic [15:0] MASK_BANK_4 = 16'h002f;
  localparam logic [15:0] MASK_BANK_5 = 16'h007f;
  localparam logic [15:0] MASK_BANK_6 = 16'h0001;
  localparam logic [15:0] MASK_BANK_7 = 16'h0030;
  localparam logic [15:0] MASK_BANK_8 = 16'h00fc;

  localparam logic [15:0] RESET_BANK = 16'h0000;

  // Field positions
  localparam int unsigned BIT_USB = 0;
  localparam int unsigned BIT_VDET = 1;
  localparam int unsigned BIT_CTU = 2;
  localparam int unsigned BIT_REFO = 3;
  localparam int unsigned BIT_UART4 = 5;
  localparam int unsigned BIT_SPI3 = 0;
  localparam int unsigned BIT_DMA_A = 4;
  localparam int unsigned BIT_DMA_B = 5;
  localparam int unsigned CCP_COUNT = 7;
  localparam int unsigned BIT_CLC_LO = 2;
  localparam int unsigned CLC_COUNT = 4;
  localparam int unsigned BIT_UART5 = 6;
  localparam int unsigned BIT_UART6 = 7;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic usb;
    logic vdet;
    logic ctu;
    logic refo;
    logic uart4;
    logic [6:0] ccp;
    logic spi3;
    logic dma_a;
    logic dma_b;
    logic [3:0] clc;
    logic uart5;
    logic uart6;
  } periph_en_type;

  localparam int unsigned NUM_PERIPH = 21;

endpackage

// ---- rtl/gate_bank.sv ----
// One gating bank: masked storage of implemented disable bits
`timescale 1ns/1ps
`default_nettype none
module gate_bank
  import pgate_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hffff
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] bits_q
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bits_q <= RESET_BANK;
    end
    else if (wr_en)
    begin
      bits_q <= wdata & MASK;
    end
  end

  AST_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
    (bits_q & ~MASK) == 16'h0000)
    else $error("unimplemented gate bit is set");

endmodule
`default_nettype wire

// ---- rtl/peripheral_gate_registers.sv ----
// Peripheral gate banks four to eight with per-peripheral clock and power enables
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module peripheral_gate_registers
  import pgate_pkg::*;
#(
  parameter bit HAS_USB = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output periph_en_type clk_en,
  output periph_en_type pwr_en,
  output periph_en_type reg_access_en
);

  logic [15:0] bank_q [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_wr;

  localparam logic [15:0] BANK_MASKS [NUM_BANKS] = '{MASK_BANK_4, MASK_BANK_5,
    MASK_BANK_6, MASK_BANK_7, MASK_BANK_8};
  localparam logic [3:0] BANK_ADDRS [NUM_BANKS] = '{ADDR_BANK_4, ADDR_BANK_5,
    ADDR_BANK_6, ADDR_BANK_7, ADDR_BANK_8};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++)
    begin : g_bank
      assign bank_wr[gi] = wr && (addr == BANK_ADDRS[gi]);
      gate_bank #(
        .MASK(BANK_MASKS[gi])
      ) gate_bank_inst (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(bank_wr[gi]),
        .wdata(wdata),
        .bits_q(bank_q[gi])
      );
    end
  endgenerate

  // Unmapped addresses read as zero; read data is held only in the cycle after rd
  function automatic logic [15:0] read_mux(input logic [3:0] a, input logic [15:0] b0,
    input logic [15:0] b1, input logic [15:0] b2, input logic [15:0] b3,
    input logic [15:0] b4);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      ADDR_BANK_4: r = b0;
      ADDR_BANK_5: r = b1;
      ADDR_BANK_6: r = b2;
      ADDR_BANK_7: r = b3;
      ADDR_BANK_8: r = b4;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 16'h0000;
    end
    else if (rd)
    begin
      rdata <= read_mux(addr, bank_q[0], bank_q[1], bank_q[2], bank_q[3], bank_q[4]);
    end
    else
    begin
      rdata <= 16'h0000;
    end
  end

  periph_en_type dis_d;

  always_comb
  begin
    dis_d = '0;
    // Without USB the bit still stores but drives nothing
    dis_d.usb = bank_q[0][BIT_USB] | ~HAS_USB;
    dis_d.vdet = bank_q[0][BIT_VDET];
    dis_d.ctu = bank_q[0][BIT_CTU];
    dis_d.refo = bank_q[0][BIT_REFO];
    dis_d.uart4 = bank_q[0][BIT_UART4];
    dis_d.ccp = bank_q[1][CCP_COUNT-1:0];
    dis_d.spi3 = bank_q[2][BIT_SPI3];
    dis_d.dma_b = bank_q[3][BIT_DMA_B];
    dis_d.dma_a = bank_q[3][BIT_DMA_A];
    dis_d.clc = bank_q[4][BIT_CLC_LO +: CLC_COUNT];
    dis_d.uart5 = bank_q[4][BIT_UART5];
    dis_d.uart6 = bank_q[4][BIT_UART6];
  end

  // Registered so enables change one cycle after the write, glitch-free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_en <= '1;
      pwr_en <= '1;
    end
    else
    begin
      clk_en <= ~dis_d;
      pwr_en <= ~dis_d;
    end
  end

  // Peripheral register ports must qualify their strobes with this enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_access_en <= '1;
    end
    else
    begin
      reg_access_en <= ~dis_d;
    end
  end

  AST_WRITE_DISABLES: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_6 && wdata[0]) |=> ##1 !clk_en.spi3)
    else $error("serial port three not disabled after write");
  AST_VDET: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_4) |=> ##1 (pwr_en.vdet == !$past(wdata[1], 2)))
    else $error("voltage detector enable wrong");
  AST_USB: assert property (@(posedge clk) disable iff (!rst_n)
    HAS_USB && bank_q[0][0] |=> !clk_en.usb)
    else $error("usb not gated");
  AST_CCP: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.ccp == ~$past(bank_q[1][6:0]))
    else $error("capture unit enables wrong");
  AST_READ_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_7) |=> (rdata & ~MASK_BANK_7) == 16'h0000)
    else $error("unimplemented bits read nonzero");
  AST_DMA_B: assert property (@(posedge clk) disable iff (!rst_n)
    bank_q[3][5] |=> !pwr_en.dma_b && !clk_en.dma_b)
    else $error("dma b not gated");
  AST_DMA_A: assert property (@(posedge clk) disable iff (!rst_n)
    !bank_q[3][4] |=> pwr_en.dma_a && clk_en.dma_a)
    else $error("dma a not enabled");
  AST_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 reg_access_en.vdet == !$past(bank_q[0][BIT_VDET]))
    else $error("voltage detector access enable wrong");
  AST_RESET: assert property (@(posedge clk)
    $rose(rst_n) |-> bank_q[0] == 16'h0000 && bank_q[3] == 16'h0000)
    else $error("gate bits not clear after reset");
  AST_RDATA_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");

  // Every write lands masked in its own bank and leaves the others alone
  AST_WR_BANK4: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_4) |=> bank_q[0] == ($past(wdata) & MASK_BANK_4))
    else $error("bank four write not stored");
  AST_WR_BANK5: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_5) |=> bank_q[1] == ($past(wdata) & MASK_BANK_5))
    else $error("bank five write not stored");
  AST_WR_BANK6: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_6) |=> bank_q[2] == ($past(wdata) & MASK_BANK_6))
    else $error("bank six write not stored");
  AST_WR_BANK7: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_7) |=> bank_q[3] == ($past(wdata) & MASK_BANK_7))
    else $error("bank seven write not stored");
  AST_WR_BANK8: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == ADDR_BANK_8) |=> bank_q[4] == ($past(wdata) & MASK_BANK_8))
    else $error("bank eight write not stored");
  AST_HOLD_BANK4: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == ADDR_BANK_4) |=> $stable(bank_q[0]))
    else $error("bank four changed without a write");
  AST_HOLD_BANK5: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == ADDR_BANK_5) |=> $stable(bank_q[1]))
    else $error("bank five changed without a write");
  AST_HOLD_BANK6: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == ADDR_BANK_6) |=> $stable(bank_q[2]))
    else $error("bank six changed without a write");
  AST_HOLD_BANK7: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == ADDR_BANK_7) |=> $stable(bank_q[3]))
    else $error("bank seven changed without a write");
  AST_HOLD_BANK8: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == ADDR_BANK_8) |=> $stable(bank_q[4]))
    else $error("bank eight changed without a write");
  AST_WR_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr > ADDR_BANK_8) |=> $stable(bank_q[0]) && $stable(bank_q[1]) &&
    $stable(bank_q[2]) && $stable(bank_q[3]) && $stable(bank_q[4]))
    else $error("write to an unmapped index changed a bank");

  // Read data show the addressed bank one cycle later, zero off the map
  AST_RD_BANK4: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_4) |=> rdata == $past(bank_q[0]))
    else $error("bank four read wrong");
  AST_RD_BANK5: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_5) |=> rdata == $past(bank_q[1]))
    else $error("bank five read wrong");
  AST_RD_BANK6: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_6) |=> rdata == $past(bank_q[2]))
    else $error("bank six read wrong");
  AST_RD_BANK7: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_7) |=> rdata == $past(bank_q[3]))
    else $error("bank seven read wrong");
  AST_RD_BANK8: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == ADDR_BANK_8) |=> rdata == $past(bank_q[4]))
    else $error("bank eight read wrong");
  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr > ADDR_BANK_8) |=> rdata == 16'h0000)
    else $error("unmapped index read nonzero");

  // Clock and power enables follow their gate bits one cycle behind the bank
  AST_CLK_VDET: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.vdet == !$past(bank_q[0][BIT_VDET]))
    else $error("voltage detector clock enable wrong");
  AST_CLK_CTU: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.ctu == !$past(bank_q[0][BIT_CTU]))
    else $error("charge time unit clock enable wrong");
  AST_CLK_REFO: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.refo == !$past(bank_q[0][BIT_REFO]))
    else $error("reference output clock enable wrong");
  AST_CLK_UART4: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.uart4 == !$past(bank_q[0][BIT_UART4]))
    else $error("uart four clock enable wrong");
  AST_CLK_CLC: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.clc == ~$past(bank_q[4][BIT_CLC_LO +: CLC_COUNT]))
    else $error("logic cell clock enables wrong");
  AST_CLK_UART5: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.uart5 == !$past(bank_q[4][BIT_UART5]))
    else $error("uart five clock enable wrong");
  AST_CLK_UART6: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 clk_en.uart6 == !$past(bank_q[4][BIT_UART6]))
    else $error("uart six clock enable wrong");
  AST_PWR_USB: assert property (@(posedge clk) disable iff (!rst_n)
    bank_q[0][BIT_USB] |=> !pwr_en.usb)
    else $error("usb power not removed");
  AST_PWR_CTU: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.ctu == !$past(bank_q[0][BIT_CTU]))
    else $error("charge time unit power enable wrong");
  AST_PWR_REFO: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.refo == !$past(bank_q[0][BIT_REFO]))
    else $error("reference output power enable wrong");
  AST_PWR_UART4: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.uart4 == !$past(bank_q[0][BIT_UART4]))
    else $error("uart four power enable wrong");
  AST_PWR_CCP: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.ccp == ~$past(bank_q[1][CCP_COUNT-1:0]))
    else $error("capture unit power enables wrong");
  AST_PWR_SPI3: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.spi3 == !$past(bank_q[2][BIT_SPI3]))
    else $error("serial port three power enable wrong");
  AST_PWR_CLC: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.clc == ~$past(bank_q[4][BIT_CLC_LO +: CLC_COUNT]))
    else $error("logic cell power enables wrong");
  AST_PWR_UART5: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.uart5 == !$past(bank_q[4][BIT_UART5]))
    else $error("uart five power enable wrong");
  AST_PWR_UART6: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 pwr_en.uart6 == !$past(bank_q[4][BIT_UART6]))
    else $error("uart six power enable wrong");

  // A gated peripheral loses its register strobes together with its clock
  AST_ACC_USB: assert property (@(posedge clk) disable iff (!rst_n)
    bank_q[0][BIT_USB] |=> !reg_access_en.usb)
    else $error("usb registers still reachable");
  AST_ACC_CCP: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 reg_access_en.ccp == ~$past(bank_q[1][CCP_COUNT-1:0]))
    else $error("capture unit access enables wrong");
  AST_ACC_SPI3: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 reg_access_en.spi3 == !$past(bank_q[2][BIT_SPI3]))
    else $error("serial port three access enable wrong");
  AST_ACC_DMA: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 {reg_access_en.dma_a, reg_access_en.dma_b} ==
    ~{$past(bank_q[3][BIT_DMA_A]), $past(bank_q[3][BIT_DMA_B])})
    else $error("dma access enables wrong");
  AST_ACC_CLC: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 reg_access_en.clc == ~$past(bank_q[4][BIT_CLC_LO +: CLC_COUNT]))
    else $error("logic cell access enables wrong");
  AST_RESET_EN: assert property (@(posedge clk)
    $rose(rst_n) |-> clk_en == '1 && pwr_en == '1 && reg_access_en == '1)
    else $error("enables not set after reset");

  CV_GATE_DMA: cover property (@(posedge clk) disable iff (!rst_n) $fell(clk_en.dma_b));
  CV_REENABLE: cover property (@(posedge clk) disable iff (!rst_n) $rose(clk_en.spi3));
  CV_READ_BACK: cover property (@(posedge clk) disable iff (!rst_n)
    rd ##1 rdata != 16'h0000);
  CV_UNMAPPED: cover property (@(posedge clk) disable iff (!rst_n) wr && addr > ADDR_BANK_8);
  CV_WRITE_READ: cover property (@(posedge clk) disable iff (!rst_n) wr ##1 rd);

endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the peripheral gate banks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pgate_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_prev = 1'b0;
  logic [15:0] rdata;
  periph_en_type clk_en;
  periph_en_type pwr_en;
  periph_en_type acc_en;
  logic [15:0] bank_m [0:4];
  logic [15:0] mask_m [0:4];
  logic [15:0] exp_q [$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  peripheral_gate_registers peripheral_gate_registers_inst (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk_en(clk_en),
    .pwr_en(pwr_en), .reg_access_en(acc_en));

  initial forever #10 clk = ~clk;

  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Enables are the inverse of the gate bits, packed in struct order
  function automatic logic [20:0] en_exp();
    return ~{bank_m[0][0], bank_m[0][1], bank_m[0][2], bank_m[0][3], bank_m[0][5],
      bank_m[1][6:0], bank_m[2][0], bank_m[3][4], bank_m[3][5], bank_m[4][5:2],
      bank_m[4][6], bank_m[4][7]};
  endfunction

  // Strobe is left high; the next task or idle lowers it, so no double assignment
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    rd <= 1'b0;
    wr <= 1'b1;
    @(posedge clk);
    if (a < 4'h5)
      bank_m[a] = d & mask_m[a];
  endtask

  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(a < 4'h5 ? bank_m[a] : 16'h0000);
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // Enables settle one edge after the write edge; looked at mid-cycle
  task automatic check_en();
    idle(2);
    @(negedge clk);
    chk(clk_en, en_exp());
    chk(pwr_en, en_exp());
    chk(acc_en, en_exp());
    @(posedge clk);
  endtask

  always @(posedge clk) rd_prev <= rd;

  always @(negedge clk)
    if (rd_prev === 1'b1 && exp_q.size() > 0)
      chk(21'(rdata), 21'(exp_q.pop_front()));
    else
      chk(21'(rdata), 21'h0);

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    mask_m = '{MASK_BANK_4, MASK_BANK_5, MASK_BANK_6, MASK_BANK_7, MASK_BANK_8};
    bank_m = '{5{16'h0000}};
    void'($urandom(32'h120b));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    check_en();
    for (int i = 0; i < 6; i++)
      rd_reg(4'(i));
    idle(2);
    $display("test reset values done");
    // Index 5 is unmapped: writes vanish and reads return zero
    for (int n = 0; n < 12; n++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        wr_reg(4'(i), n == 0 ? 16'hffff : (n == 11 ? 16'h0000 : 16'($urandom)));
        rd_reg(4'(i));
      end
      check_en();
    end
    $display("test write and readback done");
    rst_n <= 1'b0;
    bank_m = '{5{16'h0000}};
    idle(2);
    rst_n <= 1'b1;
    check_en();
    $display("test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
